// [inc/rct_defines.svh]
`ifndef RCT_DEFINES_SVH
`define RCT_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define RCT_ADDR_W 8
`define RCT_OFS_CONTROL 8'h1e
`define RCT_OFS_RELOAD_HIGH 8'h1f
`define RCT_OFS_RELOAD_LOW 8'h20
`define RCT_OFS_COUNT_HIGH 8'h21
`define RCT_OFS_COUNT_LOW 8'h22
`define RCT_OFS_IRQ_STATUS 8'h30
`define RCT_OFS_IRQ_CLEAR 8'h31
`define RCT_OFS_IRQ_ENABLE 8'h32
`define RCT_OFS_COMMAND 8'h33

// ------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------
`define RCT_CTL_STOP_RX_BIT 7
`define RCT_CTL_START_MSB 5
`define RCT_CTL_START_LSB 4
`define RCT_CTL_RELOAD_BIT 3
`define RCT_CTL_TICK_MSB 1
`define RCT_CTL_TICK_LSB 0

// ------------------------------------------------------------
// Interrupt and command bits
// ------------------------------------------------------------
`define RCT_IRQ_UNDERFLOW_BIT 0
`define RCT_IRQ_RX_STOP_BIT 1
`define RCT_CMD_START_BIT 0
`define RCT_CMD_STOP_BIT 1

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define RCT_CONTROL_RESET 8'h00
`define RCT_RELOAD_RESET 16'h0000
`define RCT_IRQ_ENABLE_RESET 8'h00
`define RCT_FAST_FREQ_KHZ 13560
`define RCT_SLOW_FREQ_HZ 211875
`define RCT_SLOW_DIVIDE ((`RCT_FAST_FREQ_KHZ * 1000) / `RCT_SLOW_FREQ_HZ)

`endif

// [inc/rct_pkg.sv]
`default_nettype none

package rct_pkg;

   // ---------------------------------------------------------
   // Start modes
   // ---------------------------------------------------------
   typedef enum logic [1:0]
   {
      RCT_START_MANUAL = 2'h0,
      RCT_START_TX_END = 2'h1,
      RCT_START_TRIM_NO_UF = 2'h2,
      RCT_START_TRIM_UF = 2'h3
   } rct_start_t;

   // ---------------------------------------------------------
   // Tick sources
   // ---------------------------------------------------------
   typedef enum logic [1:0]
   {
      RCT_TICK_FAST = 2'h0,
      RCT_TICK_SLOW = 2'h1,
      RCT_TICK_TIMER_ZERO = 2'h2,
      RCT_TICK_TIMER_ONE = 2'h3
   } rct_tick_t;

   // ---------------------------------------------------------
   // Control register contents
   // ---------------------------------------------------------
   typedef struct packed
   {
      logic stop_on_receive;
      rct_start_t start_mode_select;
      logic reload_on_zero;
      rct_tick_t tick_source_select;
   } rct_ctrl_t;

   // ---------------------------------------------------------
   // Events from the transceiver, reference oscillator, fast tick and sibling timers
   // ---------------------------------------------------------
   typedef struct packed
   {
      logic tx_done;
      logic rx_first_bits;
      logic low_freq_oscillator_rise;
      logic fast_tick;
      logic timer_zero_underflow;
      logic timer_one_underflow;
   } rct_events_t;

endpackage : rct_pkg

`default_nettype wire

// [verilog/rct_tick_div.sv]
`include "rct_defines.svh"
`default_nettype none

// Divides the fast tick enable down to the slow tick enable
module rct_tick_div #(
   parameter int DIVIDE = `RCT_SLOW_DIVIDE
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Fast tick in, slow tick out
   input wire logic i_fast_tick,
   output logic o_slow_tick
);

   localparam int CW = $clog2(DIVIDE);
   localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

   logic [CW-1:0] cnt_q;
   logic slow_q;

   // ---------------------------------------------------------
   // Fast tick counter
   // ---------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         cnt_q <= '0;
         slow_q <= 1'b0;
      end
      else
      begin
         slow_q <= i_fast_tick && (cnt_q == LAST);
         if (i_fast_tick)
         begin
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
         end
      end
   end

   assign o_slow_tick = slow_q;

endmodule : rct_tick_div

`default_nettype wire

// [verilog/rct_timer.sv]
`include "rct_defines.svh"
`default_nettype none

// Functional notes
// - With stop-on-receive set, halt at once after the first four received bits.
// - In oscillator trimming modes the stop-on-receive bit has no effect.
// - Start mode 00 never self-starts; 01 starts when a transmission ends.
// - Modes 10 and 11 start and stop on reference rising edges; 11 underflows.
// - Auto-restart set: reload from the reload word at zero and keep counting, except in mode 10.
// - Auto-restart clear: count down to zero and stop without reload.
// - Every underflow sets the underflow interrupt flag.
// - Tick source 00 is the fast clock, 01 the slow divided clock.
// - Tick source 10 counts timer zero underflows, 11 timer one underflows.
// - Reload word is high byte bits 15..8 and low byte bits 7..0.
// - Each start copies both reload bytes together into the counter.
// - Reload writes do not disturb a running count; used at next start or next auto-restart reload.
// - High byte of the live count is readable.
// - Low byte of the live count is readable in its own register.
module rct_timer #(
   parameter int WIDTH = 16,
   parameter int SLOW_DIVIDE = `RCT_SLOW_DIVIDE
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Register port
   input wire logic [`RCT_ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rd_data,
   // Transceiver, reference and sibling events
   input wire rct_pkg::rct_events_t i_events,
   // Timer state and cascade
   output logic o_running,
   output logic o_underflow,
   // Interrupt
   output logic o_irq
);

   // ---------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------
   rct_pkg::rct_ctrl_t ctrl_q;
   logic [7:0] reload_high_byte_q;
   logic [7:0] reload_low_byte_q;
   logic [WIDTH-1:0] reload_word;
   logic [WIDTH-1:0] count_q;
   logic running_q;
   logic underflow_q;
   logic [1:0] irq_status_q;
   logic [1:0] irq_status_d;
   logic [1:0] irq_enable_q;
   logic [7:0] rd_data_q;
   logic slow_tick;
   logic tick;
   logic trim_mode;
   logic sw_start;
   logic sw_stop;
   logic tx_start;
   logic trim_edge;
   logic rx_stop;
   logic start_event;
   logic stop_event;
   logic at_zero;
   logic uf_allowed;
   logic uf_event;
   logic [1:0] irq_events;
   logic [1:0] irq_clear;

   // ---------------------------------------------------------
   // Write decode helper
   // ---------------------------------------------------------
   function automatic logic wr_hit(input logic [`RCT_ADDR_W-1:0] ofs);
      wr_hit = i_wr && (i_addr == ofs);
   endfunction : wr_hit

   // Control byte with reserved bits forced to zero
   function automatic logic [7:0] ctrl_to_byte(input rct_pkg::rct_ctrl_t c);
      logic [7:0] b;
      b = 8'h00;
      b[`RCT_CTL_STOP_RX_BIT] = c.stop_on_receive;
      b[`RCT_CTL_START_MSB:`RCT_CTL_START_LSB] = c.start_mode_select;
      b[`RCT_CTL_RELOAD_BIT] = c.reload_on_zero;
      b[`RCT_CTL_TICK_MSB:`RCT_CTL_TICK_LSB] = c.tick_source_select;
      ctrl_to_byte = b;
   endfunction : ctrl_to_byte

   // Byte to control fields, shared by reset and write
   function automatic rct_pkg::rct_ctrl_t byte_to_ctrl(input logic [7:0] b);
      rct_pkg::rct_ctrl_t c;
      c.stop_on_receive = b[`RCT_CTL_STOP_RX_BIT];
      c.start_mode_select = rct_pkg::rct_start_t'(b[`RCT_CTL_START_MSB:`RCT_CTL_START_LSB]);
      c.reload_on_zero = b[`RCT_CTL_RELOAD_BIT];
      c.tick_source_select = rct_pkg::rct_tick_t'(b[`RCT_CTL_TICK_MSB:`RCT_CTL_TICK_LSB]);
      byte_to_ctrl = c;
   endfunction : byte_to_ctrl

   // ---------------------------------------------------------
   // Slow tick divider
   // ---------------------------------------------------------
   rct_tick_div #(
      .DIVIDE(SLOW_DIVIDE)
   ) u_div (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_fast_tick(i_events.fast_tick),
      .o_slow_tick(slow_tick)
   );

   // ---------------------------------------------------------
   // Control register
   // ---------------------------------------------------------
   // Reserved bits 6 and 2 are never stored
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         ctrl_q <= byte_to_ctrl(`RCT_CONTROL_RESET);
      end
      else if (wr_hit(`RCT_OFS_CONTROL))
      begin
         ctrl_q <= byte_to_ctrl(i_wr_data);
      end
   end

   // ---------------------------------------------------------
   // Reload bytes
   // ---------------------------------------------------------
   // Stored only; the counter picks them up at a start or at an auto-restart reload at zero
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         reload_high_byte_q <= 8'(`RCT_RELOAD_RESET >> 8);
         reload_low_byte_q <= 8'(`RCT_RELOAD_RESET);
      end
      else
      begin
         if (wr_hit(`RCT_OFS_RELOAD_HIGH))
         begin
            reload_high_byte_q <= i_wr_data;
         end
         if (wr_hit(`RCT_OFS_RELOAD_LOW))
         begin
            reload_low_byte_q <= i_wr_data;
         end
      end
   end

   // Both bytes joined into one word
   assign reload_word = WIDTH'({reload_high_byte_q, reload_low_byte_q});

   // ---------------------------------------------------------
   // Tick selection
   // ---------------------------------------------------------
   always_comb
   begin
      case (ctrl_q.tick_source_select)
         rct_pkg::RCT_TICK_FAST: tick = i_events.fast_tick;
         rct_pkg::RCT_TICK_SLOW: tick = slow_tick;
         rct_pkg::RCT_TICK_TIMER_ZERO: tick = i_events.timer_zero_underflow;
         rct_pkg::RCT_TICK_TIMER_ONE: tick = i_events.timer_one_underflow;
         default: tick = 1'b0;
      endcase
   end

   // ---------------------------------------------------------
   // Start and stop events
   // ---------------------------------------------------------
   assign trim_mode = ctrl_q.start_mode_select[1];
   assign sw_start = wr_hit(`RCT_OFS_COMMAND) && i_wr_data[`RCT_CMD_START_BIT];
   assign sw_stop = wr_hit(`RCT_OFS_COMMAND) && i_wr_data[`RCT_CMD_STOP_BIT];
   // Transmission end starts the count only in mode 01
   assign tx_start = i_events.tx_done &&
      (ctrl_q.start_mode_select == rct_pkg::RCT_START_TX_END);
   // Reference rising edge toggles the count in trimming modes
   assign trim_edge = i_events.low_freq_oscillator_rise && trim_mode;
   // Receive stop is dropped while trimming
   assign rx_stop = i_events.rx_first_bits && ctrl_q.stop_on_receive &&
      !trim_mode && running_q;
   assign start_event = sw_start || tx_start || (trim_edge && !running_q);
   assign stop_event = sw_stop || rx_stop || (trim_edge && running_q);

   // ---------------------------------------------------------
   // Underflow decode
   // ---------------------------------------------------------
   assign at_zero = (count_q == '0);
   // Trimming without underflow stops at zero instead
   assign uf_allowed =
      (ctrl_q.start_mode_select != rct_pkg::RCT_START_TRIM_NO_UF);
   assign uf_event = running_q && !stop_event && !start_event && tick &&
      at_zero && uf_allowed;

   // ---------------------------------------------------------
   // Counter and run state
   // ---------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         count_q <= '0;
         running_q <= 1'b0;
      end
      else if (stop_event)
      begin
         running_q <= 1'b0;
      end
      else if (start_event)
      begin
         count_q <= reload_word;
         running_q <= 1'b1;
      end
      else if (running_q && tick)
      begin
         if (!at_zero)
         begin
            count_q <= count_q - 1'b1;
         end
         else if (!uf_allowed)
         begin
            running_q <= 1'b0;
         end
         else if (ctrl_q.reload_on_zero)
         begin
            count_q <= reload_word;
         end
         else
         begin
            running_q <= 1'b0;
         end
      end
   end

   // Cascade pulse for other timers
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         underflow_q <= 1'b0;
      end
      else
      begin
         underflow_q <= uf_event;
      end
   end

   assign o_running = running_q;
   assign o_underflow = underflow_q;

   // ---------------------------------------------------------
   // Interrupt status, enable and clear
   // ---------------------------------------------------------
   assign irq_events[`RCT_IRQ_UNDERFLOW_BIT] = uf_event;
   assign irq_events[`RCT_IRQ_RX_STOP_BIT] = rx_stop;
   assign irq_clear = wr_hit(`RCT_OFS_IRQ_CLEAR) ? i_wr_data[1:0] : 2'h0;
   // A new event wins over a clear in the same cycle
   assign irq_status_d = (irq_status_q & ~irq_clear) | irq_events;

   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         irq_status_q <= 2'h0;
      end
      else
      begin
         irq_status_q <= irq_status_d;
      end
   end

   // Enable mask
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         irq_enable_q <= 2'(`RCT_IRQ_ENABLE_RESET);
      end
      else if (wr_hit(`RCT_OFS_IRQ_ENABLE))
      begin
         irq_enable_q <= i_wr_data[1:0];
      end
   end

   assign o_irq = |(irq_status_q & irq_enable_q);

   // ---------------------------------------------------------
   // Read port
   // ---------------------------------------------------------
   // Data stand one cycle after the read strobe only
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         rd_data_q <= 8'h00;
      end
      else if (i_rd)
      begin
         case (i_addr)
            `RCT_OFS_CONTROL: rd_data_q <= ctrl_to_byte(ctrl_q);
            `RCT_OFS_RELOAD_HIGH: rd_data_q <= reload_high_byte_q;
            `RCT_OFS_RELOAD_LOW: rd_data_q <= reload_low_byte_q;
            `RCT_OFS_COUNT_HIGH: rd_data_q <= 8'(count_q >> 8);
            `RCT_OFS_COUNT_LOW: rd_data_q <= 8'(count_q);
            `RCT_OFS_IRQ_STATUS: rd_data_q <= {6'h00, irq_status_q};
            `RCT_OFS_IRQ_ENABLE: rd_data_q <= {6'h00, irq_enable_q};
            default: rd_data_q <= 8'h00;
         endcase
      end
      else
      begin
         rd_data_q <= 8'h00;
      end
   end

   assign o_rd_data = rd_data_q;

endmodule : rct_timer

`default_nettype wire

// [tb/rct_timer_chk.sv]
`default_nettype none

// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module rct_timer_chk (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rd_data,
   // Events, state and interrupt
   input wire rct_pkg::rct_events_t i_events,
   input wire logic o_running,
   input wire logic o_underflow,
   input wire logic o_irq
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [7:0] ctl_q;
   logic [15:0] rl_q;
   logic [1:0] en_q;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);

   // Shadow of control, reload and enable
   always_ff @(posedge i_clk)
   begin
      if (i_reset)
      begin
         ctl_q <= 8'h00;
         rl_q <= 16'h0000;
         en_q <= 2'h0;
      end
      else if (i_wr)
      begin
         if (i_addr == 8'h1e) ctl_q <= i_wr_data & 8'hbb;
         if (i_addr == 8'h1f) rl_q[15:8] <= i_wr_data;
         if (i_addr == 8'h20) rl_q[7:0] <= i_wr_data;
         if (i_addr == 8'h32) en_q <= i_wr_data[1:0];
      end
   end

   // Command start with no competing stop
   sequence s_start;
      i_wr && i_addr == 8'h33 && i_wr_data[1:0] == 2'h1 && !i_events.low_freq_oscillator_rise
         && !i_events.rx_first_bits;
   endsequence

   // Quiet cycle then read of the count high byte
   sequence s_read_high;
      !i_events.fast_tick && ctl_q[1:0] == 2'h0 ##1 i_rd && i_addr == 8'h21;
   endsequence

   chk_start_runs: assert property (s_start |=> o_running)
      else $error("start did not run");
   chk_start_loads: assert property (s_start ##1 s_read_high |=> o_rd_data == rl_q[15:8])
      else $error("start did not load reload word");
   chk_uf_reload: assert property (o_underflow |-> o_running == $past(ctl_q[3]))
      else $error("underflow run state wrong");
   chk_uf_irq: assert property (o_underflow && en_q[0] |-> o_irq)
      else $error("underflow did not raise irq");
   chk_irq_masked: assert property (en_q == 2'h0 |-> !o_irq)
      else $error("irq while all masked");
   chk_rx_stop: assert property (o_running && i_events.rx_first_bits && ctl_q[7]
      && !ctl_q[5] && !i_wr |=> !o_running)
      else $error("receive did not stop timer");
   chk_rx_ignored: assert property (o_running && i_events.rx_first_bits
      && (!ctl_q[7] || ctl_q[5]) && !i_wr && !i_events.low_freq_oscillator_rise
      && !i_events.fast_tick && ctl_q[1:0] == 2'h0 |=> o_running)
      else $error("timer stopped on receive");
   chk_ctrl_read: assert property (i_rd && i_addr == 8'h1e |=> o_rd_data == $past(ctl_q))
      else $error("control readback wrong");
   chk_reload_read: assert property (i_rd && (i_addr == 8'h1f || i_addr == 8'h20)
      |=> o_rd_data == $past(i_addr[0] ? rl_q[15:8] : rl_q[7:0]))
      else $error("reload readback wrong");
endmodule : rct_timer_chk

bind rct_timer rct_timer_chk chk_u (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
   .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
   .i_events(i_events), .o_running(o_running), .o_underflow(o_underflow), .o_irq(o_irq));

`default_nettype wire

// [tb/tb_rct_timer.sv]
`default_nettype none

module tb_rct_timer;
   timeunit 1ns;
   timeprecision 1ns;

   logic i_clk, i_reset, i_wr, i_rd, o_running, o_underflow, o_irq;
   logic [7:0] i_addr, i_wr_data, o_rd_data;
   rct_pkg::rct_events_t i_events;
   int failures = 0;
   int samples_checked = 0;
   int uf_cnt = 0;
   logic [7:0] addrs [10] = '{8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h30, 8'h31, 8'h32, 8'h33,
      8'h05};

   rct_timer #(.SLOW_DIVIDE(4)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
      .i_events(i_events), .o_running(o_running), .o_underflow(o_underflow), .o_irq(o_irq));

   // Clock
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // Underflow pulse counter
   always @(posedge i_clk)
      if (o_underflow === 1'b1) uf_cnt++;

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      check(o_rd_data, e);
   endtask : rd

   task automatic pulse(input int b);
      @(posedge i_clk);
      i_events <= rct_pkg::rct_events_t'(6'h01 << b);
      @(posedge i_clk);
      i_events <= '0;
      #1;
   endtask : pulse

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   // Watchdog
   initial
   begin
      repeat (5000) @(posedge i_clk);
      failures++;
      stop_test;
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      i_reset = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wr_data = 8'h00;
      i_events = '0;
      repeat (12) @(posedge i_clk);
      i_reset <= 1'b0;
      foreach (addrs[k]) rd(addrs[k], 8'h00);
      wr(8'h1e, 8'hff);
      rd(8'h1e, 8'hbb);
      wr(8'h1f, 8'h12);
      wr(8'h20, 8'h34);
      wr(8'h21, 8'h55);
      rd(8'h1f, 8'h12);
      rd(8'h20, 8'h34);
      rd(8'h21, 8'h00);
      $display("test registers done");
      wr(8'h1e, 8'h00);
      wr(8'h1f, 8'h00);
      wr(8'h20, 8'h03);
      wr(8'h32, 8'h01);
      wr(8'h33, 8'h01);
      rd(8'h21, 8'h00);
      rd(8'h22, 8'h03);
      pulse(2);
      rd(8'h22, 8'h02);
      pulse(2);
      pulse(2);
      check({7'h0, o_running}, 8'h01);
      pulse(2);
      check({7'h0, o_running}, 8'h00);
      check({7'h0, o_irq}, 8'h01);
      rd(8'h30, 8'h01);
      check(8'(uf_cnt), 8'h01);
      rd(8'h22, 8'h00);
      wr(8'h32, 8'h00);
      check({7'h0, o_irq}, 8'h00);
      wr(8'h31, 8'h01);
      rd(8'h30, 8'h00);
      wr(8'h32, 8'h01);
      $display("test one shot done");
      wr(8'h1e, 8'h08);
      wr(8'h20, 8'h01);
      wr(8'h33, 8'h01);
      pulse(2);
      pulse(2);
      check({7'h0, o_running}, 8'h01);
      rd(8'h22, 8'h01);
      wr(8'h1f, 8'h02);
      rd(8'h21, 8'h00);
      wr(8'h33, 8'h02);
      check({7'h0, o_running}, 8'h00);
      wr(8'h33, 8'h01);
      rd(8'h21, 8'h02);
      check(8'(uf_cnt), 8'h02);
      $display("test auto restart done");
      wr(8'h20, 8'h05);
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h1e, 8'(s));
         wr(8'h33, 8'h01);
         if (s != 2) pulse(1);
         if (s != 3) pulse(0);
         if (s != 0) repeat (4) pulse(2);
         if (s == 0) pulse(2);
         if (s > 1) pulse(3 - s);
         rd(8'h22, 8'h04);
      end
      $display("test tick sources done");
      wr(8'h33, 8'h02);
      wr(8'h1e, 8'h00);
      pulse(5);
      check({7'h0, o_running}, 8'h00);
      wr(8'h1e, 8'h10);
      pulse(5);
      check({7'h0, o_running}, 8'h01);
      pulse(4);
      check({7'h0, o_running}, 8'h01);
      wr(8'h31, 8'h03);
      wr(8'h1e, 8'h90);
      pulse(4);
      check({7'h0, o_running}, 8'h00);
      rd(8'h30, 8'h02);
      wr(8'h1e, 8'ha0);
      pulse(3);
      check({7'h0, o_running}, 8'h01);
      pulse(4);
      check({7'h0, o_running}, 8'h01);
      pulse(3);
      check({7'h0, o_running}, 8'h00);
      wr(8'h1f, 8'h00);
      wr(8'h20, 8'h01);
      for (int m = 2; m < 4; m++)
      begin
         wr(8'h31, 8'h03);
         wr(8'h1e, 8'(m << 4));
         pulse(3);
         pulse(2);
         pulse(2);
         check({7'h0, o_running}, 8'h00);
         rd(8'h30, 8'(m - 2));
      end
      $display("test start modes done");
      stop_test;
   end
endmodule : tb_rct_timer

`default_nettype wire
